/* File: hw/sac_ctrl.sv */
// successive-approximation conversion control: triggers, timing, flags, format
// assumes an analog comparator answering each trial bit and timers on clk_i
//
// Contract
// (R1) converter works only while enable is 1; otherwise shut down.
// (R2) each completed conversion loads the high and low result bytes.
// (R3) results are 10-bit unsigned; unused result bits read 0.
// (R4) justify 0 puts code in low ten bits; 1 in top ten bits.
// (R5) eight-bit mode resolves top eight bits into high byte, ignores justify.
// (R6) eight-bit conversion ends two conversion clocks sooner than ten-bit.
// (R7) ten-bit conversion takes 13 conversion clocks, eight-bit takes 11.
// (R8) conversion clock is system clock divided by period field plus one.
// (R9) start field selects software, four timer overflows or pin rising edge.
// (R10) codes 0..5: software, timer0, timer2, timer1, pin edge, timer3.
// (R11) with software source a busy write of 1 starts one conversion.
// (R12) busy stays 1 for the whole conversion and clears at completion.
// (R13) busy falling sets the complete flag and requests an enabled interrupt.
// (R14) software polls the complete flag, then reads results.
// (R15) timers 2 and 3 use low overflows split, high overflows when 16-bit.
// (R16) pin routing skips the start pin when it is the trigger.
// (R17) delayed tracking postpones conversion start by three conversion clocks.
// (R18) without delayed tracking conversion starts right on the trigger.
// (R19) internal sources: track whenever not converting.
// (R20) pin source: track if delayed mode, else only while pin low.
// (R21) triggers during a busy conversion are ignored.
// (R22) right-justified ten-bit high byte bits 7..2 read zero.
`timescale 1ns/1ps
`include "sac_map.svh"

module sac_ctrl #(
    parameter int CODE_BITS = `SAC_CODE_BITS
) (
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    input  wire sac_pkg::sac_cfg_type   cfg_i,
    input  wire sac_pkg::sac_timer_type timers_i,
    input  wire logic                   busy_write_i,
    input  wire logic                   flag_clear_i,
    input  wire logic                   int_enable_i,
    input  wire logic                   external_start_pin_i,
    input  wire logic                   cmp_high_i,
    output logic                        conversion_busy_o,
    output logic                        conversion_complete_flag_o,
    output logic                        irq_o,
    output logic                        track_o,
    output logic                        powered_o,
    output logic                        sar_clk_en_o,
    output logic [CODE_BITS-1:0]        dac_trial_o,
    output logic                        pin_skip_o,
    output sac_pkg::sac_result_type     result_o
);
    import sac_pkg::*;

    // the layout in pack_result is written for a 10-bit code only
    if (CODE_BITS != 10)
    begin : g_width_check
        $error("sac_ctrl serves only a 10-bit code");
    end

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_TRACK = 4'b0010,
        ST_CONV  = 4'b0100,
        ST_DONE  = 4'b1000
    } sac_state_type;

    // pin synchroniser; only the second and third stages are compared
    logic [2:0]    pin_sync;
    logic          pin_level;
    logic          pin_prev;
    logic [2:0]    next_pin_sync;
    logic          next_pin_level;
    logic          next_pin_prev;

    sac_state_type state;
    sac_state_type next_state;
    logic [4:0]    div_cnt;
    logic [4:0]    next_div_cnt;
    logic [3:0]    cyc_cnt;
    logic [3:0]    next_cyc_cnt;
    logic [9:0]    sar;
    logic [9:0]    next_sar;
    logic          mode8;
    logic          next_mode8;
    logic          busy;
    logic          next_busy;
    logic          flag;
    logic          next_flag;
    sac_result_type result;
    sac_result_type next_result;

    logic          tick;
    logic          trigger;
    logic          pin_rise;

    // conversion-clock tick from the period field
    function automatic logic div_tick(input logic [4:0] cnt,
                                      input logic [4:0] period);
        div_tick = (cnt == period);
    endfunction : div_tick

    // resolved code laid out for software
    function automatic sac_result_type pack_result(input logic [9:0] code,
                                                   input logic       m8,
                                                   input logic       lj);
        if (m8)
            pack_result = {code[9:2], 8'h00}; // R5
        else if (lj)
            pack_result = {code, `SAC_LJUST_PAD}; // R4
        else
            pack_result = {`SAC_RJUST_PAD, code}; // R4 R22
    endfunction : pack_result

    // pin synchroniser next values
    always_comb
    begin
        next_pin_sync  = {pin_sync[1:0], external_start_pin_i};
        next_pin_level = pin_level;
        if (pin_sync[1] == pin_sync[2])
            next_pin_level = pin_sync[2];
        next_pin_prev  = pin_level;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            pin_sync  <= 3'h0;
            pin_level <= 1'b0;
            pin_prev  <= 1'b0;
        end
        else
        begin
            pin_sync  <= next_pin_sync;
            pin_level <= next_pin_level;
            pin_prev  <= next_pin_prev;
        end
    end

    assign pin_rise = pin_level & ~pin_prev;
    assign tick     = div_tick(div_cnt, cfg_i.conv_clock_period_field); // R8

    // start source selection; unused codes never start
    always_comb
    begin
        unique case (cfg_i.start_source_select) // R9 R10
            `SAC_SRC_SOFT: trigger = busy_write_i; // R11
            `SAC_SRC_TMR0: trigger = timers_i.t0_ovf;
            `SAC_SRC_TMR2: trigger = timers_i.t2_split8 ?
                                     timers_i.t2_lo_ovf :
                                     timers_i.t2_hi_ovf; // R15
            `SAC_SRC_TMR1: trigger = timers_i.t1_ovf;
            `SAC_SRC_PIN:  trigger = pin_rise;
            `SAC_SRC_TMR3: trigger = timers_i.t3_split8 ?
                                     timers_i.t3_lo_ovf :
                                     timers_i.t3_hi_ovf; // R15
            default:       trigger = 1'b0;
        endcase
    end

    // sequencer next values
    always_comb
    begin
        next_state   = state;
        next_div_cnt = tick ? 5'h00 : div_cnt + 5'h01;
        next_cyc_cnt = cyc_cnt;
        next_sar     = sar;
        next_mode8   = mode8;
        next_busy    = busy;
        next_flag    = flag;
        next_result  = result;
        if (flag_clear_i)
            next_flag = 1'b0;
        if (!cfg_i.converter_enable)
        begin
            next_state   = ST_IDLE; // R1
            next_div_cnt = 5'h00;
            next_busy    = 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    // only ST_IDLE samples triggers, so a running conversion never sees them
                    if (trigger) // R21
                    begin
                        next_busy    = 1'b1; // R12
                        next_mode8   = cfg_i.eight_bit_mode_bit;
                        next_sar     = 10'h200;
                        next_div_cnt = 5'h00;
                        if (cfg_i.delayed_tracking_mode)
                        begin
                            next_state   = ST_TRACK; // R17
                            next_cyc_cnt = 4'(`SAC_TRACK_CYC - 1);
                        end
                        else
                        begin
                            next_state   = ST_CONV; // R18
                            next_cyc_cnt = 4'h0;
                        end
                    end
                end
                ST_TRACK:
                begin
                    if (tick)
                    begin
                        if (cyc_cnt == 4'h0)
                            next_state = ST_CONV;
                        else
                            next_cyc_cnt = cyc_cnt - 4'h1;
                    end
                end
                ST_CONV:
                begin
                    // cycle 0 holds, cycles 1..10 (or 1..8) trial bits,
                    // last cycles settle the result
                    if (tick)
                    begin
                        next_cyc_cnt = cyc_cnt + 4'h1;
                        if (cyc_cnt >= 4'h1 && cyc_cnt <= 4'ha)
                        begin
                            if (!cmp_high_i)
                                next_sar[10 - cyc_cnt] = 1'b0;
                            if (cyc_cnt < 4'ha)
                                next_sar[9 - cyc_cnt] = 1'b1;
                            if (mode8 && cyc_cnt >= 4'h8)
                                next_sar[1:0] = 2'b00; // R3
                        end
                        if (cyc_cnt == (mode8 ? 4'(`SAC_SAR_CYC_8 - 1)
                                              : 4'(`SAC_SAR_CYC_10 - 1)))
                            next_state = ST_DONE; // R6 R7
                    end
                end
                ST_DONE:
                begin
                    next_result = pack_result(sar, mode8,
                                              cfg_i.left_justify_select); // R2
                    next_busy   = 1'b0; // R12
                    next_flag   = 1'b1; // R13
                    next_state  = ST_IDLE;
                end
                default:
                    next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            state   <= ST_IDLE;
            div_cnt <= 5'h00;
            cyc_cnt <= 4'h0;
            sar     <= 10'h000;
            mode8   <= 1'b0;
            busy    <= 1'b0;
            flag    <= 1'b0;
            result  <= 16'h0000;
        end
        else
        begin
            state   <= next_state;
            div_cnt <= next_div_cnt;
            cyc_cnt <= next_cyc_cnt;
            sar     <= next_sar;
            mode8   <= next_mode8;
            busy    <= next_busy;
            flag    <= next_flag;
            result  <= next_result;
        end
    end

    // outputs; tracking follows source and pin as described
    assign conversion_busy_o          = busy;
    assign conversion_complete_flag_o = flag;
    assign irq_o       = flag & int_enable_i; // R13
    assign powered_o   = cfg_i.converter_enable; // R1
    assign sar_clk_en_o = tick & cfg_i.converter_enable;
    assign dac_trial_o = sar;
    assign pin_skip_o  = (cfg_i.start_source_select == `SAC_SRC_PIN); // R16
    assign result_o    = result;
    always_comb
    begin
        if (!cfg_i.converter_enable)
            track_o = 1'b0;
        else if (state == ST_CONV || state == ST_DONE)
            track_o = 1'b0;
        else if (cfg_i.start_source_select == `SAC_SRC_PIN &&
                 !cfg_i.delayed_tracking_mode && state == ST_IDLE)
            track_o = ~pin_level; // R20
        else
            track_o = 1'b1; // R19
    end

    // assertions
    busy_fall_flag_a: assert property ( // R13
        @(posedge clk_i) disable iff (!nrst_i)
        $fell(busy) && $past(cfg_i.converter_enable) |-> flag)
        else $error("busy fell without setting complete flag");
    off_idle_a: assert property ( // R1
        @(posedge clk_i) disable iff (!nrst_i)
        !$past(cfg_i.converter_enable) |-> !busy)
        else $error("busy while disabled");
    ignore_trig_a: assert property ( // R21
        @(posedge clk_i) disable iff (!nrst_i)
        state == ST_CONV && trigger |=> state != ST_TRACK)
        else $error("trigger restarted a conversion");
    // a shutdown in the done cycle keeps the old result, so enable is asked
    rjust_zero_a: assert property ( // R22
        @(posedge clk_i) disable iff (!nrst_i)
        state == ST_DONE && !mode8 && !cfg_i.left_justify_select &&
        cfg_i.converter_enable
        |=> result.result_high_byte[7:2] == 6'h00)
        else $error("right-justified high bits not zero");
    eight_low_a: assert property ( // R5
        @(posedge clk_i) disable iff (!nrst_i)
        state == ST_DONE && mode8 && cfg_i.converter_enable
        |=> result.result_low_byte == 8'h00)
        else $error("eight-bit low byte not zero");
    track_delay_a: assert property ( // R17
        @(posedge clk_i) disable iff (!nrst_i)
        state == ST_IDLE && trigger && cfg_i.delayed_tracking_mode &&
        cfg_i.converter_enable |=> state == ST_TRACK && busy)
        else $error("delayed tracking not entered");
    no_delay_a: assert property ( // R18
        @(posedge clk_i) disable iff (!nrst_i)
        state == ST_IDLE && trigger && !cfg_i.delayed_tracking_mode &&
        cfg_i.converter_enable |=> state == ST_CONV)
        else $error("conversion did not start at once");
    conv_track_a: assert property ( // R19
        @(posedge clk_i) disable iff (!nrst_i)
        state == ST_CONV |-> !track_o)
        else $error("tracking during conversion");
    bad_code_a: assert property ( // R10
        @(posedge clk_i) disable iff (!nrst_i)
        cfg_i.start_source_select > 3'h5 && state == ST_IDLE
        |=> state == ST_IDLE)
        else $error("unused source code started a conversion");
    retrig_hold_a: assert property ( // R21
        @(posedge clk_i) disable iff (!nrst_i)
        (state == ST_TRACK || state == ST_CONV) && trigger &&
        cfg_i.converter_enable |=> busy && $stable(mode8))
        else $error("trigger disturbed a running conversion");
    done_clear_a: assert property ( // R12
        @(posedge clk_i) disable iff (!nrst_i)
        state == ST_DONE && cfg_i.converter_enable
        |=> !busy && flag && state == ST_IDLE)
        else $error("busy or flag wrong after completion");
    // after a tick the divider restarts, so only a zero period ticks again
    tick_gap_a: assert property ( // R8
        @(posedge clk_i) disable iff (!nrst_i)
        sar_clk_en_o && cfg_i.conv_clock_period_field != 5'h00
        |=> !sar_clk_en_o || cfg_i.conv_clock_period_field == 5'h00)
        else $error("conversion clock ticked twice in a row");
endmodule : sac_ctrl

/* File: hw/sac_map.svh */
// conversion-control constants: source codes, pad values, reset values, cycle counts
// assumes inclusion by the design module only
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_CODE_BITS       10
`define SAC_SAR_CYC_10      13
`define SAC_SAR_CYC_8       11
`define SAC_TRACK_CYC       3
`define SAC_CLKDIV_RESET    5'h1f
`define SAC_SRC_SOFT        3'h0
`define SAC_SRC_TMR0        3'h1
`define SAC_SRC_TMR2        3'h2
`define SAC_SRC_TMR1        3'h3
`define SAC_SRC_PIN         3'h4
`define SAC_SRC_TMR3        3'h5
`define SAC_LJUST_PAD       6'h00
`define SAC_RJUST_PAD       6'h00
`endif

/* File: hw/sac_pkg.sv */
// types shared by the conversion-control block
// uses no constants from sac_map.svh
package sac_pkg;
    // configuration bits that software holds steady between conversions
    typedef struct packed {
        logic       converter_enable;
        logic [4:0] conv_clock_period_field;
        logic       left_justify_select;
        logic       eight_bit_mode_bit;
        logic [2:0] start_source_select;
        logic       delayed_tracking_mode;
    } sac_cfg_type;

    // timer overflow pulses, low and high byte for timers 2 and 3
    typedef struct packed {
        logic t0_ovf;
        logic t1_ovf;
        logic t2_lo_ovf;
        logic t2_hi_ovf;
        logic t2_split8;
        logic t3_lo_ovf;
        logic t3_hi_ovf;
        logic t3_split8;
    } sac_timer_type;

    // result pair as software reads it
    typedef struct packed {
        logic [7:0] result_high_byte;
        logic [7:0] result_low_byte;
    } sac_result_type;
endpackage : sac_pkg

/* File: testbench/sac_cmp_model.sv */
// comparator model facing the trial word of the conversion control
// assumes the held input level is steady for a whole conversion
`timescale 1ns/1ps

module sac_cmp_model (
    input  wire logic [9:0] dac_trial_i,
    input  wire logic [9:0] level_i,
    output logic            cmp_high_o
);
    // keep the trial bit while the held level is at or above the trial word
    assign cmp_high_o = (level_i >= dac_trial_i);
endmodule : sac_cmp_model

/* File: testbench/testbench.sv */
// self-checking bench for the conversion control: formats, timing, sources
// assumes the comparator model in sac_cmp_model.sv and the sac_pkg package
`timescale 1ns/1ps

module testbench;
    import sac_pkg::*;
    logic           clk_i;
    logic           nrst_i;
    logic           busy_write_i;
    logic           flag_clear_i;
    logic           int_enable_i;
    logic           pin;
    logic           cmp;
    logic           busy;
    logic           flag;
    logic           irq;
    logic           track;
    logic           powered;
    logic [9:0]     trial;
    logic [9:0]     level;
    logic           skip;
    logic           sclk;
    logic           split;
    sac_cfg_type    cfg;
    sac_timer_type  tmr;
    sac_result_type res;
    logic [15:0]    exp_res;
    int             mismatches;
    int             comparisons;
    int             cycles;
    int             n;

    sac_ctrl DUT (.clk_i(clk_i), .nrst_i(nrst_i), .cfg_i(cfg),
        .timers_i(tmr), .busy_write_i(busy_write_i),
        .flag_clear_i(flag_clear_i), .int_enable_i(int_enable_i),
        .external_start_pin_i(pin), .cmp_high_i(cmp),
        .conversion_busy_o(busy), .conversion_complete_flag_o(flag),
        .irq_o(irq), .track_o(track), .powered_o(powered),
        .sar_clk_en_o(sclk), .dac_trial_o(trial), .pin_skip_o(skip),
        .result_o(res));

    sac_cmp_model partner (.dac_trial_i(trial), .level_i(level),
        .cmp_high_o(cmp));

    // free-running system clock, 25 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // hang guard: the whole run needs about a thousand cycles
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    task check(input string name, input logic [15:0] seen,
               input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one trigger event; 6 and 7 are overflows of the unused timer byte
    task pulse(input int k);
        @(negedge clk_i);
        case (k)
            0: busy_write_i = 1'b1;
            1: tmr.t0_ovf = 1'b1;
            2: if (split) tmr.t2_lo_ovf = 1'b1; else tmr.t2_hi_ovf = 1'b1;
            3: tmr.t1_ovf = 1'b1;
            4: pin = 1'b1;
            5: if (split) tmr.t3_lo_ovf = 1'b1; else tmr.t3_hi_ovf = 1'b1;
            6: if (split) tmr.t2_hi_ovf = 1'b1; else tmr.t2_lo_ovf = 1'b1;
            default: if (split) tmr.t3_hi_ovf = 1'b1;
                     else tmr.t3_lo_ovf = 1'b1;
        endcase
        @(negedge clk_i);
        busy_write_i = 1'b0;
        tmr = '{t2_split8: split, t3_split8: split, default: 1'b0};
    endtask : pulse

    // count busy cycles, poll the complete flag, then clear it
    task measure(output int cnt);
        cnt = 0;
        repeat (12) if (busy !== 1'b1) @(negedge clk_i);
        while (busy === 1'b1 && cnt < 2000)
        begin
            cnt++;
            @(negedge clk_i);
        end
        repeat (3) if (flag !== 1'b1) @(negedge clk_i);
        pin = 1'b0;
        check("flag", flag, 1);
        check("irq", irq, int_enable_i);
        flag_clear_i = 1'b1;
        @(negedge clk_i);
        flag_clear_i = 1'b0;
        check("flag_clr", flag, 0);
    endtask : measure

    task end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        {nrst_i, busy_write_i, flag_clear_i, int_enable_i, pin} = '0;
        split = 1'b0;
        tmr = '0;
        cfg = '0;
        cfg.converter_enable = 1'b1;
        level = 10'h02a5;
        repeat (20) @(negedge clk_i);
        nrst_i = 1'b1;
        check("busy_rst", busy, 0);
        check("res_rst", res, 16'h0000);
        check("powered_on", powered, 1);
        check("sclk_on", sclk, 1);
        // formats at two levels; three modes each
        for (int v = 0; v < 2; v++)
        begin
            level = v ? 10'h03ff : 10'h02a5;
            for (int f = 0; f < 3; f++)
            begin
                int_enable_i = (f == 1);
                cfg.left_justify_select = (f != 0);
                cfg.eight_bit_mode_bit = (f == 2);
                pulse(0);
                measure(n);
                check("len", n, f == 2 ? 12 : 14);
                exp_res = f == 0 ? {6'h00, level} : f == 1 ?
                    {level, 6'h00} : {level[9:2], 8'h00};
                check("result", res, exp_res);
            end
        end
        $display("test formats done");
        cfg.eight_bit_mode_bit = 1'b0;
        cfg.left_justify_select = 1'b0;
        cfg.delayed_tracking_mode = 1'b1;
        pulse(0);
        measure(n);
        check("len_delay", n, 17);
        cfg.delayed_tracking_mode = 1'b0;
        cfg.conv_clock_period_field = 5'h03;
        for (int f = 0; f < 2; f++)
        begin
            cfg.eight_bit_mode_bit = 1'(f);
            pulse(0);
            measure(n);
            check("len_div", n, f ? 45 : 53);
        end
        cfg.eight_bit_mode_bit = 1'b0;
        cfg.conv_clock_period_field = 5'h00;
        $display("test timing done");
        // a second start in mid-conversion must change nothing
        pulse(0);
        repeat (4) @(negedge clk_i);
        check("track_conv", track, 0);
        pulse(0);
        measure(n);
        check("len_retrig", n, 8);
        check("res_retrig", res, {6'h00, level});
        // shutdown in mid-conversion aborts without a flag
        pulse(0);
        repeat (3) @(negedge clk_i);
        cfg.converter_enable = 1'b0;
        repeat (2) @(negedge clk_i);
        check("busy_off", busy, 0);
        check("flag_off", flag, 0);
        check("powered", powered, 0);
        check("sclk_off", sclk, 0);
        cfg.converter_enable = 1'b1;
        @(negedge clk_i);
        $display("test busy and shutdown done");
        // every source code against every other trigger, both timer widths
        for (int sp = 0; sp < 2; sp++)
        begin
            split = 1'(sp);
            int_enable_i = 1'(sp);
            for (int s = 0; s < 8; s++)
            begin
                cfg.start_source_select = 3'(s);
                for (int k = 0; k < 8; k++)
                    if (k != s) pulse(k);
                repeat (8) @(negedge clk_i);
                pin = 1'b0;
                repeat (6) @(negedge clk_i);
                check("busy_decoy", busy, 0);
                check("pin_skip", skip, s == 4);
                if (s < 6)
                begin
                    check("track_idle", track, 1);
                    pulse(s);
                    measure(n);
                    if (s == 4) check("track_pin", track, 0);
                    check("len_src", n, 14);
                end
            end
        end
        $display("test sources done");
        end_of_test();
    end
endmodule : testbench
